//--- core/srm_pkg.sv
`default_nettype none
package srm_pkg;
  // Clock and timing.
  localparam longint CLK_HZ = 64'd20000000;
  localparam longint RESTART_SHORT_MS = 64'd100;
  localparam longint RESTART_LONG_MS = 64'd500;
  localparam longint MUTE_SHORT_MIN = 64'd10;
  localparam longint MUTE_LONG_H = 64'd100;
  localparam longint RESTART_SHORT_CYC = RESTART_SHORT_MS * CLK_HZ / 64'd1000;
  localparam longint RESTART_LONG_CYC = RESTART_LONG_MS * CLK_HZ / 64'd1000;
  localparam longint MUTE_SHORT_CYC = MUTE_SHORT_MIN * 64'd60 * CLK_HZ;
  localparam longint MUTE_LONG_CYC = MUTE_LONG_H * 64'd3600 * CLK_HZ;
  localparam int DELAY_W = 24;
  localparam int MUTE_W = 43;

  // Register byte offsets.
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_OUTDATA = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_CODE = 5'h0C;
  localparam logic [4:0] OFS_CODE_TABLE = 5'h10;

  // Field positions.
  localparam int CTRL_DELAY_BIT = 0;
  localparam int CTRL_INTF_BIT = 1;
  localparam int OUT_IND_BIT = 0;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_INTERLOCK_BIT = 3;
  localparam int ST_CONTACTOR_BIT = 4;
  localparam int ST_FAULT_BIT = 5;
  localparam int ST_RESTART_OK_BIT = 6;
  localparam int ST_LONG_TO_BIT = 7;
  localparam int ST_SEQ_BIT = 8;
  localparam int ST_OUT_EN_BIT = 9;
  localparam int TBL_IDX_LSB = 4;

  // Reset values.
  localparam logic RST_DELAY_SEL = 1'b0;
  localparam logic RST_INTF_FLAG = 1'b0;
  localparam logic RST_INDICATOR = 1'b0;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Muting operating modes; zero means none or undecodable.
  localparam logic [2:0] MODE_NONE = 3'h0;
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_5 = 3'h5;
  localparam logic [2:0] MODE_6 = 3'h6;

  typedef enum logic [2:0] {
    REG_CTRL,
    REG_OUTDATA,
    REG_STATUS,
    REG_CODE,
    REG_CODE_TABLE,
    REG_NONE
  } srm_reg_t;

  typedef enum logic [1:0] {
    ST_SAMPLE,
    ST_RUN,
    ST_FAULT
  } srm_state_t;
endpackage
`default_nettype wire

//--- core/srm_code_mem.sv
`timescale 1ns/1ps
`default_nettype none
module srm_code_mem (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Write port.
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [3:0] wr_data,
  // Read port.
  input wire logic [2:0] rd_addr,
  output logic [3:0] rd_data_q
);
  logic [3:0] mem_q [8];

  // Cleared at reset so the code register never shows an unknown nibble.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        mem_q[i] <= 4'h0;
      end
      rd_data_q <= 4'h0;
    end else begin
      if (wr_en) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule
`default_nettype wire

//--- core/srm_top.sv
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE1] Restart delay 100 ms or 500 ms.
// [RULE2] Master sets interference flag; interference clears it.
// [RULE3] Port bus-only; never steers safety decisions.
// [RULE4] Indicator output follows output data bit.
// [RULE5] Safety code nibbles delivered to master.
// [RULE6] Feedback at +24 V disables contactor check.
// [RULE7] Non-muting: bridged strap disables restart interlock.
// [RULE8] Muting models: restart interlock always on.
// [RULE9] Restart button supplies +24 V to input.
// [RULE10] Mode from supply polarity and bridge pin.
// [RULE11] Normal 1/2/4, reversed 5/3/6 per bridge.
// [RULE12] Timeout 10 min, 100 h in modes 2/4.
// [RULE13] Sequence control modes 3/4, else timing.
// [RULE14] Interlock always; contactor check not modes 4/6.
// [RULE15] Extension 1/5/6, enable 5, partial 6.
// [RULE16] Second muting input also from machine plug.
// [RULE17] Muting functions gated by decoded mode.
// [RULE18] Straps sampled once after reset only.
// [RULE19] Invalid straps: fault, safety outputs held off.
module srm_top #(
  parameter longint RESTART_SHORT_P = srm_pkg::RESTART_SHORT_CYC,
  parameter longint RESTART_LONG_P = srm_pkg::RESTART_LONG_CYC,
  parameter longint MUTE_SHORT_P = srm_pkg::MUTE_SHORT_CYC,
  parameter longint MUTE_LONG_P = srm_pkg::MUTE_LONG_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite slave.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [4:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Configuration straps.
  input wire logic muting_model,
  input wire logic eight_pin_socket,
  input wire logic feedback_high,
  input wire logic mode_strap_high,
  input wire logic supply_normal,
  input wire logic supply_reversed,
  input wire logic bridge_pin4,
  input wire logic bridge_pin8,
  input wire logic bridge_pin3,
  // Machine-side live signals.
  input wire logic beam_clear,
  input wire logic restart_button,
  input wire logic interference_evt,
  input wire logic socket_muting_input,
  input wire logic plug_muting_input,
  input wire logic timeout_extension_input,
  // Decoded configuration and results.
  output logic [2:0] mode_q,
  output logic restart_interlock_q,
  output logic contactor_feedback_check_q,
  output logic config_fault_q,
  output logic sequence_ctrl_q,
  output logic four_sensor_q,
  output logic ext_allowed_q,
  output logic enable_allowed_q,
  output logic partial_allowed_q,
  output logic [srm_pkg::MUTE_W-1:0] mute_timeout_cyc_q,
  output logic second_muting_q,
  output logic timeout_ext_q,
  output logic restart_ok_q,
  output logic safety_out_en_q,
  output logic indicator_output_bit_q,
  output logic [3:0] safety_code_inputs_q
);
  import srm_pkg::*;

  typedef struct packed {
    srm_state_t st;
    logic [2:0] mode;
    logic interlock;
    logic contactor;
    logic fault;
    logic seq_ctrl;
    logic four_sensor;
    logic ext_ok;
    logic en_ok;
    logic part_ok;
    logic long_to;
    logic [MUTE_W-1:0] mute_to;
    logic second_mute;
    logic ext_live;
    logic delay_sel;
    logic intf_flag;
    logic indicator;
    logic [DELAY_W-1:0] cnt;
    logic delay_done;
    logic released;
    logic btn_prev;
    logic out_en;
    logic [2:0] code_idx;
    logic [3:0] code;
    logic tbl_we;
    logic [2:0] tbl_addr;
    logic [3:0] tbl_data;
    logic aw_got;
    logic w_got;
    logic [4:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } srm_regs_t;

  localparam logic [DELAY_W-1:0] SHORT_LIM = DELAY_W'(RESTART_SHORT_P - 64'd1);
  localparam logic [DELAY_W-1:0] LONG_LIM = DELAY_W'(RESTART_LONG_P - 64'd1);

  srm_regs_t state_q;
  srm_regs_t state_d;
  logic [3:0] mem_rd;
  logic aw_hs;
  logic w_hs;
  logic wr_fire;
  logic ar_hs;
  logic [4:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane;
  srm_reg_t wr_reg;
  srm_reg_t rd_reg;
  logic [DELAY_W-1:0] lim;

  // Same decoder serves both channels so reads and writes agree on the map.
  function automatic srm_reg_t reg_decode(input logic [4:0] addr);
    case (addr)
      OFS_CTRL: reg_decode = REG_CTRL;
      OFS_OUTDATA: reg_decode = REG_OUTDATA;
      OFS_STATUS: reg_decode = REG_STATUS;
      OFS_CODE: reg_decode = REG_CODE;
      OFS_CODE_TABLE: reg_decode = REG_CODE_TABLE;
      default: reg_decode = REG_NONE;
    endcase
  endfunction

  // Exactly one polarity and one bridge must be present, else no mode.
  function automatic logic [2:0] mode_decode(input logic norm, input logic rev,
                                             input logic b4, input logic b8,
                                             input logic b3);
    logic [2:0] m;
    m = MODE_NONE;
    if (norm && !rev) begin
      case ({b4, b8, b3})
        3'h4: m = MODE_1;
        3'h2: m = MODE_2;
        3'h1: m = MODE_4;
        default: m = MODE_NONE;
      endcase
    end else if (rev && !norm) begin
      case ({b4, b8, b3})
        3'h4: m = MODE_5;
        3'h2: m = MODE_3;
        3'h1: m = MODE_6;
        default: m = MODE_NONE;
      endcase
    end
    mode_decode = m;
  endfunction

  always_comb begin
    state_d = state_q;
    aw_hs = s_axi_awvalid && state_q.awready;
    w_hs = s_axi_wvalid && state_q.wready;
    ar_hs = s_axi_arvalid && state_q.arready;
    wr_addr = aw_hs ? s_axi_awaddr : state_q.awaddr;
    wr_byte = w_hs ? s_axi_wdata[7:0] : state_q.wdata;
    wr_lane = w_hs ? s_axi_wstrb[0] : state_q.wstrb0;
    wr_fire = (state_q.aw_got || aw_hs) && (state_q.w_got || w_hs) && !state_q.bvalid;
    wr_reg = reg_decode(wr_addr);
    rd_reg = reg_decode(s_axi_araddr);
    lim = state_q.delay_sel ? LONG_LIM : SHORT_LIM;
    state_d.tbl_we = 1'b0;

    // Straps are read once; later wiring changes need a reset.
    case (state_q.st)
      ST_SAMPLE: begin
        if (muting_model) begin
          state_d.mode = mode_decode(supply_normal, supply_reversed, bridge_pin4,
                                     bridge_pin8, bridge_pin3); // [RULE10] [RULE11]
          state_d.interlock = 1'b1; // [RULE8] [RULE14]
          state_d.fault = (state_d.mode == MODE_NONE); // [RULE19]
        end else begin
          state_d.mode = MODE_NONE;
          state_d.interlock = mode_strap_high; // [RULE7]
          state_d.fault = 1'b0;
        end
        state_d.contactor = !feedback_high && (!muting_model ||
          (state_d.mode != MODE_4 && state_d.mode != MODE_6)); // [RULE6] [RULE14]
        state_d.seq_ctrl = (state_d.mode == MODE_3) || (state_d.mode == MODE_4); // [RULE13]
        state_d.four_sensor = muting_model && eight_pin_socket && !state_d.seq_ctrl; // [RULE13]
        state_d.long_to = (state_d.mode == MODE_2) || (state_d.mode == MODE_4); // [RULE12]
        state_d.mute_to = state_d.long_to ? MUTE_W'(MUTE_LONG_P) : MUTE_W'(MUTE_SHORT_P); // [RULE12]
        state_d.ext_ok = (state_d.mode == MODE_1) || (state_d.mode == MODE_5) ||
                         (state_d.mode == MODE_6); // [RULE15] [RULE17]
        state_d.en_ok = (state_d.mode == MODE_5); // [RULE15]
        state_d.part_ok = (state_d.mode == MODE_6); // [RULE15]
        state_d.st = state_d.fault ? ST_FAULT : ST_RUN; // [RULE18] [RULE19]
      end
      ST_RUN: state_d.st = ST_RUN;
      ST_FAULT: state_d.st = ST_FAULT;
      default: state_d.st = ST_FAULT;
    endcase

    // The plug input only counts in modes that route the second sensor there.
    state_d.second_mute = socket_muting_input || (plug_muting_input &&
      (state_q.mode == MODE_2 || state_q.mode == MODE_3 ||
       state_q.mode == MODE_4)); // [RULE16]
    state_d.ext_live = timeout_extension_input && state_q.ext_ok; // [RULE17]

    // A beam interruption restarts the delay and withdraws any release.
    state_d.btn_prev = restart_button;
    if (!beam_clear) begin
      state_d.cnt = '0; // [RULE1]
      state_d.delay_done = 1'b0;
      state_d.released = 1'b0;
    end else if (!state_q.delay_done) begin
      if (state_q.cnt >= lim) begin
        state_d.delay_done = 1'b1; // [RULE1]
      end else begin
        state_d.cnt = state_q.cnt + DELAY_W'(1);
      end
    end else if (!state_q.interlock || (restart_button && !state_q.btn_prev)) begin
      state_d.released = 1'b1; // [RULE9]
    end
    // Only the beam path, restart button and straps gate the outputs; port data only picks the delay length.
    state_d.out_en = (state_q.st == ST_RUN) && state_q.released && beam_clear; // [RULE3] [RULE19]

    // Write channel: address and data may arrive in either order.
    if (aw_hs) begin
      state_d.aw_got = 1'b1;
      state_d.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      state_d.w_got = 1'b1;
      state_d.wdata = s_axi_wdata[7:0];
      state_d.wstrb0 = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      state_d.aw_got = 1'b0;
      state_d.w_got = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = RESP_OKAY;
      case (wr_reg)
        REG_CTRL: begin
          if (wr_lane) begin
            state_d.delay_sel = wr_byte[CTRL_DELAY_BIT]; // [RULE1]
            if (wr_byte[CTRL_INTF_BIT]) begin
              state_d.intf_flag = 1'b1; // [RULE2]
            end
          end
        end
        REG_OUTDATA: begin
          if (wr_lane) begin
            state_d.indicator = wr_byte[OUT_IND_BIT]; // [RULE4]
          end
        end
        REG_CODE_TABLE: begin
          state_d.tbl_we = wr_lane;
          state_d.tbl_addr = wr_byte[TBL_IDX_LSB+2:TBL_IDX_LSB];
          state_d.tbl_data = wr_byte[3:0];
        end
        REG_STATUS, REG_CODE: state_d.bresp = RESP_OKAY;
        default: state_d.bresp = RESP_SLVERR;
      endcase
    end else if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end
    // Hardware interference beats a same-cycle software set.
    if (interference_evt) begin
      state_d.intf_flag = 1'b0; // [RULE2]
    end
    state_d.awready = !state_d.aw_got && !state_d.bvalid;
    state_d.wready = !state_d.w_got && !state_d.bvalid;

    // Read channel; each read of the code register steps the sequence.
    state_d.code = mem_rd;
    if (ar_hs) begin
      state_d.rvalid = 1'b1;
      state_d.rdata = '0;
      state_d.rresp = RESP_OKAY;
      case (rd_reg)
        REG_CTRL: begin
          state_d.rdata[CTRL_DELAY_BIT] = state_q.delay_sel;
          state_d.rdata[CTRL_INTF_BIT] = state_q.intf_flag; // [RULE2]
        end
        REG_OUTDATA: state_d.rdata[OUT_IND_BIT] = state_q.indicator;
        REG_STATUS: begin
          state_d.rdata[ST_MODE_LSB+2:ST_MODE_LSB] = state_q.mode;
          state_d.rdata[ST_INTERLOCK_BIT] = state_q.interlock;
          state_d.rdata[ST_CONTACTOR_BIT] = state_q.contactor;
          state_d.rdata[ST_FAULT_BIT] = state_q.fault;
          state_d.rdata[ST_RESTART_OK_BIT] = state_q.released;
          state_d.rdata[ST_LONG_TO_BIT] = state_q.long_to;
          state_d.rdata[ST_SEQ_BIT] = state_q.seq_ctrl;
          state_d.rdata[ST_OUT_EN_BIT] = state_q.out_en;
        end
        REG_CODE: begin
          state_d.rdata[3:0] = state_q.code; // [RULE5]
          state_d.code_idx = state_q.code_idx + 3'h1; // [RULE5]
        end
        REG_CODE_TABLE: state_d.rresp = RESP_OKAY;
        default: state_d.rresp = RESP_SLVERR;
      endcase
    end else if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end
    state_d.arready = !state_d.rvalid;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= '{st: ST_SAMPLE, delay_sel: RST_DELAY_SEL, intf_flag: RST_INTF_FLAG,
                   indicator: RST_INDICATOR, bresp: RESP_OKAY, rresp: RESP_OKAY,
                   default: '0};
    end else begin
      state_q <= state_d;
    end
  end

  srm_code_mem u_code_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(state_q.tbl_we),
    .wr_addr(state_q.tbl_addr),
    .wr_data(state_q.tbl_data),
    .rd_addr(state_q.code_idx),
    .rd_data_q(mem_rd)
  );

  assign s_axi_awready = state_q.awready;
  assign s_axi_wready = state_q.wready;
  assign s_axi_bvalid = state_q.bvalid;
  assign s_axi_bresp = state_q.bresp;
  assign s_axi_arready = state_q.arready;
  assign s_axi_rvalid = state_q.rvalid;
  assign s_axi_rdata = state_q.rdata;
  assign s_axi_rresp = state_q.rresp;
  assign mode_q = state_q.mode;
  assign restart_interlock_q = state_q.interlock;
  assign contactor_feedback_check_q = state_q.contactor;
  assign config_fault_q = state_q.fault;
  assign sequence_ctrl_q = state_q.seq_ctrl;
  assign four_sensor_q = state_q.four_sensor;
  assign ext_allowed_q = state_q.ext_ok;
  assign enable_allowed_q = state_q.en_ok;
  assign partial_allowed_q = state_q.part_ok;
  // Latched with the straps so the count never changes while muting runs.
  assign mute_timeout_cyc_q = state_q.mute_to; // [RULE12]
  assign second_muting_q = state_q.second_mute;
  assign timeout_ext_q = state_q.ext_live;
  assign restart_ok_q = state_q.released;
  assign safety_out_en_q = state_q.out_en;
  assign indicator_output_bit_q = state_q.indicator;
  assign safety_code_inputs_q = state_q.code;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_delay_end;
    beam_clear && $rose(state_q.delay_done);
  endsequence
  sequence s_out_write;
    wr_fire && wr_reg == REG_OUTDATA && wr_lane;
  endsequence

  short_delay_a: assert property ((s_delay_end and !state_q.delay_sel) |->
    $past(state_q.cnt) == SHORT_LIM) else $error("Short restart delay wrong."); // [RULE1]
  long_delay_a: assert property ((s_delay_end and state_q.delay_sel) |->
    $past(state_q.cnt) == LONG_LIM) else $error("Long restart delay wrong."); // [RULE1]
  intf_clear_a: assert property (interference_evt |=> !state_q.intf_flag)
    else $error("Interference did not clear flag."); // [RULE2]
  indicator_a: assert property (s_out_write |=> indicator_output_bit_q == $past(wr_byte[0]))
    else $error("Indicator did not follow write."); // [RULE4]
  code_step_a: assert property (ar_hs && rd_reg == REG_CODE |=>
    state_q.code_idx == $past(state_q.code_idx) + 3'h1) else $error("Code did not step."); // [RULE5]
  no_contactor_a: assert property (state_q.st != ST_SAMPLE && muting_model &&
    (mode_q == MODE_4 || mode_q == MODE_6) |-> !contactor_feedback_check_q)
    else $error("Contactor check in mode 4 or 6."); // [RULE14]
  mute_interlock_a: assert property (state_q.st != ST_SAMPLE && muting_model |->
    restart_interlock_q) else $error("Muting model without interlock."); // [RULE8]
  fault_off_a: assert property (config_fault_q |-> !safety_out_en_q [*2])
    else $error("Outputs on during fault."); // [RULE19]
  strap_hold_a: assert property (state_q.st != ST_SAMPLE && $past(state_q.st) != ST_SAMPLE
    |-> $stable(mode_q) && $stable(restart_interlock_q)) else $error("Straps resampled."); // [RULE18]
endmodule
`default_nettype wire

//--- test/srm_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Machine-side wiring: cfg 0..5 picks polarity and bridge of a muting model,
// 6 is a wiring fault, 8 and 9 are non-muting models with the strap high or bridged.
module srm_partner (
  // Selection from the bench.
  input wire logic [3:0] cfg,
  input wire logic fb,
  input wire logic e8,
  input wire logic sb,
  input wire logic press,
  // Wiring seen by the device.
  output logic muting_model,
  output logic eight_pin_socket,
  output logic feedback_high,
  output logic mode_strap_high,
  output logic supply_normal,
  output logic supply_reversed,
  output logic bridge_pin4,
  output logic bridge_pin8,
  output logic bridge_pin3,
  output logic restart_button
);
  logic mu;
  always_comb begin
    mu = cfg < 4'h7;
    muting_model = cfg < 4'h8;
    eight_pin_socket = e8;
    feedback_high = fb;
    // A muting model may leave the strap unwired, so it floats to either level.
    mode_strap_high = (cfg == 4'h8) | (muting_model & sb);
    supply_normal = (mu & ~cfg[0]) | (cfg == 4'h6) | ~muting_model;
    supply_reversed = mu & cfg[0];
    bridge_pin4 = mu & (cfg[2:1] == 2'h0);
    bridge_pin8 = mu & (cfg[2:1] == 2'h1);
    bridge_pin3 = mu & (cfg[2:1] == 2'h2);
    restart_button = press;
  end
endmodule
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import srm_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wr, bv, arr, rv;
  logic [4:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0] br, rr;
  logic [3:0] cfg = 4'h9;
  logic fb = 0, e8 = 0, sb = 0, press = 0, beam = 0, evt = 0, plug = 0, tex = 0, sock = 0;
  logic mm, e8p, fbh, msh, sn, sr, b4, b8, b3, rbt;
  logic [2:0] mode;
  logic il, cc, flt, sq, fs, exa, ena, pa, sm, te, rok, soe, ind;
  logic [42:0] mto;
  logic [3:0] code, nib [8];
  logic [7:0] lf = 8'h40;
  logic [1:0] resp;
  int n_errors = 0, checks = 0, cyc = 0, m, k;
  int mt [6] = '{1, 5, 2, 3, 4, 6};
  always #25 clk_sys = ~clk_sys;
  srm_partner par (.cfg(cfg), .fb(fb), .e8(e8), .sb(sb), .press(press), .muting_model(mm),
    .eight_pin_socket(e8p), .feedback_high(fbh), .mode_strap_high(msh), .supply_normal(sn),
    .supply_reversed(sr), .bridge_pin4(b4), .bridge_pin8(b8), .bridge_pin3(b3),
    .restart_button(rbt));
  srm_top #(.RESTART_SHORT_P(20), .RESTART_LONG_P(50), .MUTE_SHORT_P(100), .MUTE_LONG_P(200))
  uut (.clk_sys(clk_sys), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .s_axi_rdata(rd), .s_axi_rresp(rr), .muting_model(mm),
    .eight_pin_socket(e8p), .feedback_high(fbh), .mode_strap_high(msh), .supply_normal(sn),
    .supply_reversed(sr), .bridge_pin4(b4), .bridge_pin8(b8), .bridge_pin3(b3),
    .beam_clear(beam), .restart_button(rbt), .interference_evt(evt),
    .socket_muting_input(sock), .plug_muting_input(plug), .timeout_extension_input(tex),
    .mode_q(mode), .restart_interlock_q(il), .contactor_feedback_check_q(cc),
    .config_fault_q(flt), .sequence_ctrl_q(sq), .four_sensor_q(fs), .ext_allowed_q(exa),
    .enable_allowed_q(ena), .partial_allowed_q(pa), .mute_timeout_cyc_q(mto),
    .second_muting_q(sm), .timeout_ext_q(te), .restart_ok_q(rok), .safety_out_en_q(soe),
    .indicator_output_bit_q(ind), .safety_code_inputs_q(code));
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    // The whole run needs about 370 cycles; far beyond that means a hang.
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bry && bv) begin
        r = br;
        break;
      end
    end
    bry <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (arv && arr) arv <= 1'b0;
      if (rry && rv) begin
        d = rd;
        r = rr;
        break;
      end
    end
    rry <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic reset(input logic [3:0] c);
    cfg <= c;
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    // Live muting outputs follow the latched mode one cycle later.
    repeat (3) @(posedge clk_sys);
  endtask
  logic [31:0] d;
  initial begin
    @(posedge clk_sys);
    plug <= 1'b1;
    tex <= 1'b1;
    for (k = 0; k < 6; k++) begin
      m = mt[k];
      rnd();
      fb <= lf[0];
      e8 <= lf[1];
      sb <= lf[2];
      reset(k[3:0]);
      chk("mode", mode, m);
      chk("interlock", il, 1);
      chk("contactor", cc, !fb && m != 4 && m != 6);
      chk("timeout", mto, (m == 2 || m == 4) ? 200 : 100);
      chk("sequence", sq, m == 3 || m == 4);
      chk("four", fs, e8 && !(m == 3 || m == 4));
      chk("ext", exa, m == 1 || m == 5 || m == 6);
      chk("enable", ena, m == 5);
      chk("partial", pa, m == 6);
      chk("second", sm, m >= 2 && m <= 4);
      chk("ext_in", te, m == 1 || m == 5 || m == 6);
      rd_reg(OFS_STATUS, d, resp);
      chk("status", d[2:0], m);
      cfg <= 4'((k + 1) % 6);
      repeat (3) @(posedge clk_sys);
      chk("mode_held", mode, m);
      $display("test mode %0d done", m);
    end
    reset(4'h6);
    beam <= 1'b1;
    press <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk("fault", flt, 1);
    chk("fault_out", soe, 0);
    press <= 1'b0;
    beam <= 1'b0;
    $display("test fault done");
    reset(4'h8);
    chk("interlock_on", il, 1);
    beam <= 1'b1;
    repeat (30) @(posedge clk_sys);
    chk("held", rok, 0);
    press <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("released", rok, 1);
    press <= 1'b0;
    beam <= 1'b0;
    $display("test interlock done");
    reset(4'h9);
    chk("interlock_off", il, 0);
    chk("no_fault", flt, 0);
    rd_reg(OFS_CTRL, d, resp);
    chk("ctrl_rst", d[1:0], 0);
    for (int i = 0; i < 8; i++) begin
      rnd();
      nib[i] = lf[3:0];
      wr_reg(OFS_CODE_TABLE, {25'h0, i[2:0], nib[i]}, resp);
    end
    for (int i = 0; i < 8; i++) begin
      rd_reg(OFS_CODE, d, resp);
      chk("code", d[3:0], nib[i]);
    end
    beam <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("short_early", rok, 0);
    chk("code_out", code, nib[0]);
    repeat (20) @(posedge clk_sys);
    chk("short_done", rok, 1);
    chk("out_en", soe, 1);
    wr_reg(OFS_OUTDATA, 32'h1, resp);
    chk("indicator", ind, 1);
    chk("out_kept", soe, 1);
    wr_reg(OFS_CTRL, 32'h3, resp);
    rd_reg(OFS_CTRL, d, resp);
    chk("intf_set", d[1:0], 3);
    evt <= 1'b1;
    @(posedge clk_sys);
    evt <= 1'b0;
    rd_reg(OFS_CTRL, d, resp);
    chk("intf_clr", d[1:0], 1);
    beam <= 1'b0;
    repeat (2) @(posedge clk_sys);
    beam <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk("long_early", rok, 0);
    repeat (30) @(posedge clk_sys);
    chk("long_done", rok, 1);
    rd_reg(5'h14, d, resp);
    chk("unmapped", {resp, d}, {RESP_SLVERR, 32'h0});
    wr_reg(OFS_STATUS, 32'hFFFFFFFF, resp);
    chk("ro_write", resp, RESP_OKAY);
    chk("mode_ro", mode, 0);
    chk("plug_off", sm, 0);
    chk("ext_off", te, 0);
    sock <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("socket", sm, 1);
    sock <= 1'b0;
    $display("test registers done");
    stop_test();
  end
endmodule
`default_nettype wire
